// ===== hw/lcs_pkg.sv
// constants, command codes and carrier types of the lcd serial port
// assumes a 200 MHz system clock; pins arrive unsynchronised
package lcs_pkg;
  // clock and derived time figures
  localparam int SYS_CLK_HZ = 200_000_000;
  localparam int TB_SRC_HZ = 32768; // time base source after prescale
  localparam int TONE_HI_HZ = 4000; // high tone
  localparam int TB_DIV_DEF = SYS_CLK_HZ / TB_SRC_HZ;
  localparam int TONE_HALF_DEF = SYS_CLK_HZ / (2 * TONE_HI_HZ);
  // frame layout
  localparam int MODE_BITS = 3;
  localparam int ADDR_BITS = 5;
  localparam int DATA_BITS = 4;
  localparam int CMD_BITS = 9; // eight code bits and one spare
  localparam int RAM_WORDS = 32;
  localparam logic [2:0] MODE_WRITE = 3'h5;
  localparam logic [2:0] MODE_READ = 3'h6;
  localparam logic [2:0] MODE_CMD = 3'h4;
  // command codes
  localparam logic [7:0] CMD_SYS_DIS = 8'h00;
  localparam logic [7:0] CMD_SYS_EN = 8'h01;
  localparam logic [7:0] CMD_WDT_DIS = 8'h05;
  localparam logic [7:0] CMD_TIMER_EN = 8'h06;
  localparam logic [7:0] CMD_WDT_EN = 8'h07;
  localparam logic [7:0] CMD_TONE_OFF = 8'h08;
  localparam logic [7:0] CMD_TONE_ON = 8'h09;
  localparam logic [7:0] CMD_CLR_TIMER = 8'h0d;
  localparam logic [7:0] CMD_CLR_WDT = 8'h0f;
  localparam logic [7:0] CMD_SRC_XTAL = 8'h14;
  localparam logic [7:0] CMD_SRC_RC = 8'h18;
  localparam logic [7:0] CMD_SRC_EXT = 8'h1c;
  localparam logic [7:0] CMD_TONE4K = 8'h40;
  localparam logic [7:0] CMD_TONE2K = 8'h60;
  localparam logic [7:0] CMD_IRQ_DIS = 8'h80;
  localparam logic [7:0] CMD_IRQ_EN = 8'h88;
  localparam logic [3:0] GRP_DUTY = 4'h2; // low two bits: coms minus two
  localparam logic [3:0] GRP_TBSEL = 4'ha; // low three bits: n
  // clock sources and com counts
  localparam logic [1:0] SRC_RC = 2'h0;
  localparam logic [1:0] SRC_XTAL = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h2;
  localparam logic [1:0] COMS_MAX = 2'h2; // four commons
  // serial states
  typedef enum logic [2:0] {ST_MODE, ST_ADDRW, ST_ADDRR, ST_WDATA, ST_RDATA, ST_CMD, ST_DEAD} lcs_state_e;
  // configuration carried to the display side
  typedef struct packed {
    logic sysEn;
    logic tbRun;
    logic wdtMode;
    logic irqEn;
    logic toneOn;
    logic tone4k;
    logic [2:0] tbSel;
    logic [1:0] clkSrc;
    logic [1:0] comSel;
  } lcs_cfg_s;
  localparam lcs_cfg_s CFG_RESET = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0, SRC_RC, COMS_MAX};
endpackage

// ===== hw/lcs_serial_port.sv
// serial host port, display ram, time base, watchdog and tone of the lcd controller
// assumes csN, wrN, rdN and data come from pins of another clock domain
// How it works
// - chip select high: transfers ignored
// - chip select high resets serial logic
// - transfers only while chip select low
// - read strobe falling edge launches next bit
// - write strobe rising edge samples data line
// - interrupt pin is open drain, pulls low
// - differential tone pair, 2 or 4 kHz
// - clock source selectable: rc, crystal, external
// - 32x4 ram, address auto increments
// - two, three or four commons selectable
// - eight selectable time base clock rates
// - watchdog timeout holds interrupt low until cleared
// - tone pins low when disabled or off
module lcs_serial_port #(
  parameter int TB_DIV = lcs_pkg::TB_DIV_DEF,
  parameter int TONE_HALF = lcs_pkg::TONE_HALF_DEF
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // host serial pins
  input wire logic csN,
  input wire logic wrN,
  input wire logic rdN,
  input wire logic dataIn,
  output logic dataOut,
  output logic dataOeN,
  // open drain interrupt pin
  output logic irqOut,
  output logic irqOeN,
  // tone_output_pair
  output logic toneP,
  output logic toneN,
  // configuration and status
  output lcs_pkg::lcs_cfg_s cfg,
  output logic wdtFlag
);
  localparam int PRE_W = $clog2(TB_DIV);
  localparam int TONE_W = $clog2(TONE_HALF);

  // pin synchronisers: {cs, wr, rd, data}
  logic [3:0] pinS1_q, pinS2_q, pinS3_q;
  logic csHigh, wrRise, rdFall, din;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pinS1_q <= 4'hf;
      pinS2_q <= 4'hf;
      pinS3_q <= 4'hf;
    end else begin
      pinS1_q <= {csN, wrN, rdN, dataIn};
      pinS2_q <= pinS1_q;
      pinS3_q <= pinS2_q;
    end
  end

  // edge finding on the second and third stages only
  assign csHigh = pinS2_q[3];
  assign din = pinS2_q[0];
  assign wrRise = pinS2_q[2] && !pinS3_q[2];
  assign rdFall = !pinS2_q[1] && pinS3_q[1];

  // display ram, one nibble per address
  logic [lcs_pkg::DATA_BITS-1:0] ram [lcs_pkg::RAM_WORDS];
  logic [lcs_pkg::DATA_BITS-1:0] ramQ, wdat;
  logic ramWe;

  // serial state
  lcs_pkg::lcs_state_e state_q, state_d;
  logic [3:0] bitCnt_q, bitCnt_d; // bit position in field
  logic [8:0] shift_q, shift_d; // received bits
  logic [lcs_pkg::ADDR_BITS-1:0] addr_q, addr_d;
  logic dataOut_q, dataOut_d;
  logic dataOeN_q, dataOeN_d;
  lcs_pkg::lcs_cfg_s cfg_q, cfg_d;
  logic clrWdt, clrTmr; // one-cycle clear commands
  logic [7:0] cmd;
  assign cmd = shift_q[7:0];
  // ram read port at the current access address
  assign ramQ = ram[addr_q];

  // serial next state
  always_comb begin
    state_d = state_q;
    bitCnt_d = bitCnt_q;
    shift_d = shift_q;
    addr_d = addr_q;
    dataOut_d = dataOut_q;
    cfg_d = cfg_q;
    ramWe = 1'b0;
    wdat = {din, shift_q[3:1]};
    clrWdt = 1'b0;
    clrTmr = 1'b0;
    if (csHigh) begin
      // deselected: drop partial bits, back to mode field
      state_d = lcs_pkg::ST_MODE;
      bitCnt_d = 4'h0;
      shift_d = 9'h000;
    end else if (wrRise) begin
      // sample data line on write strobe rise
      shift_d = {shift_q[7:0], din};
      bitCnt_d = bitCnt_q + 4'h1;
      case (state_q)
        lcs_pkg::ST_MODE: begin
          if (bitCnt_q == 4'(lcs_pkg::MODE_BITS - 1)) begin
            bitCnt_d = 4'h0;
            // decode mode field
            if ({shift_q[1:0], din} == lcs_pkg::MODE_WRITE) begin
              state_d = lcs_pkg::ST_ADDRW;
            end else if ({shift_q[1:0], din} == lcs_pkg::MODE_READ) begin
              state_d = lcs_pkg::ST_ADDRR;
            end else if ({shift_q[1:0], din} == lcs_pkg::MODE_CMD) begin
              state_d = lcs_pkg::ST_CMD;
            end else begin
              state_d = lcs_pkg::ST_DEAD;
            end
          end
        end
        lcs_pkg::ST_ADDRW, lcs_pkg::ST_ADDRR: begin
          if (bitCnt_q == 4'(lcs_pkg::ADDR_BITS - 1)) begin
            // address complete, msb first
            bitCnt_d = 4'h0;
            addr_d = {shift_q[3:0], din};
            state_d = (state_q == lcs_pkg::ST_ADDRW) ? lcs_pkg::ST_WDATA : lcs_pkg::ST_RDATA;
          end
        end
        lcs_pkg::ST_WDATA: begin
          // nibble arrives lsb first
          shift_d = {5'h00, wdat};
          if (bitCnt_q == 4'(lcs_pkg::DATA_BITS - 1)) begin
            bitCnt_d = 4'h0;
            ramWe = 1'b1;
            addr_d = addr_q + 5'h01;
          end
        end
        lcs_pkg::ST_CMD: begin
          if (bitCnt_q == 4'(lcs_pkg::CMD_BITS - 1)) begin
            // ninth bit is spare; execute the eight before it
            bitCnt_d = 4'h0;
            case (cmd)
              lcs_pkg::CMD_SYS_DIS: cfg_d.sysEn = (cfg_q.clkSrc == lcs_pkg::SRC_EXT);
              lcs_pkg::CMD_SYS_EN: cfg_d.sysEn = 1'b1;
              lcs_pkg::CMD_WDT_DIS: cfg_d.tbRun = 1'b0;
              lcs_pkg::CMD_TIMER_EN: begin
                cfg_d.tbRun = 1'b1;
                cfg_d.wdtMode = 1'b0;
              end
              lcs_pkg::CMD_WDT_EN: begin
                cfg_d.tbRun = 1'b1;
                cfg_d.wdtMode = 1'b1;
              end
              lcs_pkg::CMD_TONE_OFF: cfg_d.toneOn = 1'b0;
              lcs_pkg::CMD_TONE_ON: cfg_d.toneOn = 1'b1;
              lcs_pkg::CMD_CLR_TIMER: clrTmr = 1'b1;
              lcs_pkg::CMD_CLR_WDT: clrWdt = 1'b1;
              lcs_pkg::CMD_SRC_XTAL: cfg_d.clkSrc = lcs_pkg::SRC_XTAL;
              lcs_pkg::CMD_SRC_RC: cfg_d.clkSrc = lcs_pkg::SRC_RC;
              lcs_pkg::CMD_SRC_EXT: cfg_d.clkSrc = lcs_pkg::SRC_EXT;
              lcs_pkg::CMD_TONE4K: cfg_d.tone4k = 1'b1;
              lcs_pkg::CMD_TONE2K: cfg_d.tone4k = 1'b0;
              lcs_pkg::CMD_IRQ_DIS: cfg_d.irqEn = 1'b0;
              lcs_pkg::CMD_IRQ_EN: cfg_d.irqEn = 1'b1;
              default: begin
                // grouped commands carry an argument
                if (cmd[7:4] == lcs_pkg::GRP_DUTY && cmd[1:0] <= lcs_pkg::COMS_MAX) begin
                  cfg_d.comSel = cmd[1:0];
                end else if (cmd[7:4] == lcs_pkg::GRP_TBSEL) begin
                  cfg_d.tbSel = cmd[2:0];
                end
              end
            endcase
          end
        end
        default: bitCnt_d = 4'h0; // read data state and dead frame ignore writes
      endcase
    end else if (rdFall && state_q == lcs_pkg::ST_RDATA) begin
      // launch next ram bit; held until the next fall for the host
      dataOut_d = ramQ[bitCnt_q[1:0]];
      bitCnt_d = bitCnt_q + 4'h1;
      if (bitCnt_q == 4'(lcs_pkg::DATA_BITS - 1)) begin
        bitCnt_d = 4'h0;
        addr_d = addr_q + 5'h01;
      end
    end
    // drive data only in a selected read
    dataOeN_d = !(state_d == lcs_pkg::ST_RDATA && !csHigh);
  end

  // serial registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= lcs_pkg::ST_MODE;
      bitCnt_q <= 4'h0;
      shift_q <= 9'h000;
      addr_q <= 5'h00;
      dataOut_q <= 1'b0;
      dataOeN_q <= 1'b1;
      cfg_q <= lcs_pkg::CFG_RESET;
    end else begin
      state_q <= state_d;
      bitCnt_q <= bitCnt_d;
      shift_q <= shift_d;
      addr_q <= addr_d;
      dataOut_q <= dataOut_d;
      dataOeN_q <= dataOeN_d;
      cfg_q <= cfg_d;
    end
  end

  // ram write port
  always_ff @(posedge sys_clk) begin
    if (ramWe) begin
      ram[addr_q] <= wdat;
    end
  end

  // time base, watchdog and tone state
  logic [PRE_W-1:0] preCnt_q, preCnt_d; // 32 kHz prescaler
  logic [6:0] divCnt_q, divCnt_d; // 2^n divider
  logic [7:0] tbCnt_q, tbCnt_d; // shared eight-stage counter
  logic [1:0] wdtCnt_q, wdtCnt_d;
  logic wdtFlag_q, wdtFlag_d;
  logic [TONE_W-1:0] toneCnt_q, toneCnt_d;
  logic toneSkip_q, toneSkip_d; // halves the rate for 2 kHz
  logic toneP_q, toneP_d, toneN_q, toneN_d;
  logic irqOeN_q, irqOeN_d;
  logic tick32, tbTick, tbOvf, toneEn;
  logic [6:0] selMask;

  // timer next state
  always_comb begin
    preCnt_d = preCnt_q;
    divCnt_d = divCnt_q;
    tbCnt_d = tbCnt_q;
    wdtCnt_d = wdtCnt_q;
    wdtFlag_d = wdtFlag_q;
    selMask = 7'((8'h01 << cfg_q.tbSel) - 8'h01);
    tick32 = cfg_q.sysEn && cfg_q.tbRun && preCnt_q == PRE_W'(TB_DIV - 1);
    tbTick = tick32 && ((divCnt_q & selMask) == selMask);
    tbOvf = tbTick && tbCnt_q == 8'hff;
    if (cfg_q.sysEn && cfg_q.tbRun) begin
      preCnt_d = tick32 ? '0 : preCnt_q + PRE_W'(1);
    end
    if (tick32) begin
      divCnt_d = divCnt_q + 7'h01;
    end
    if (tbTick) begin
      tbCnt_d = tbCnt_q + 8'h01;
    end
    if (tbOvf) begin
      wdtCnt_d = wdtCnt_q + 2'h1;
    end
    if (clrTmr || clrWdt) begin
      // clear the shared counter
      preCnt_d = '0;
      divCnt_d = 7'h00;
      tbCnt_d = 8'h00;
    end
    if (clrWdt) begin
      wdtCnt_d = 2'h0;
      wdtFlag_d = 1'b0;
    end
    // timeout sets after the watchdog clear so the set wins; a timer clear blocks it
    if (tbOvf && wdtCnt_q == 2'h3 && !clrTmr) begin
      wdtFlag_d = 1'b1;
    end
    // tone generator
    toneEn = cfg_q.sysEn && cfg_q.toneOn;
    toneCnt_d = toneCnt_q;
    toneSkip_d = toneSkip_q;
    toneP_d = toneP_q;
    toneN_d = toneN_q;
    if (!toneEn) begin
      toneCnt_d = '0;
      toneSkip_d = 1'b0;
      toneP_d = 1'b0;
      toneN_d = 1'b0;
    end else if (toneCnt_q == TONE_W'(TONE_HALF - 1)) begin
      toneCnt_d = '0;
      toneSkip_d = !toneSkip_q;
      if (cfg_q.tone4k || toneSkip_q) begin
        toneP_d = !toneP_q;
      end
      toneN_d = !toneP_d;
    end else begin
      toneCnt_d = toneCnt_q + TONE_W'(1);
      toneN_d = !toneP_q;
    end
    // pull irq low on watchdog flag or time base output
    irqOeN_d = !(cfg_q.irqEn && (cfg_q.wdtMode ? wdtFlag_q : tbCnt_q[7]));
  end

  // timer registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      preCnt_q <= '0;
      divCnt_q <= 7'h00;
      tbCnt_q <= 8'h00;
      wdtCnt_q <= 2'h0;
      wdtFlag_q <= 1'b0;
      toneCnt_q <= '0;
      toneSkip_q <= 1'b0;
      toneP_q <= 1'b0;
      toneN_q <= 1'b0;
      irqOeN_q <= 1'b1;
    end else begin
      preCnt_q <= preCnt_d;
      divCnt_q <= divCnt_d;
      tbCnt_q <= tbCnt_d;
      wdtCnt_q <= wdtCnt_d;
      wdtFlag_q <= wdtFlag_d;
      toneCnt_q <= toneCnt_d;
      toneSkip_q <= toneSkip_d;
      toneP_q <= toneP_d;
      toneN_q <= toneN_d;
      irqOeN_q <= irqOeN_d;
    end
  end

  // outputs straight from flops; irq data flop only ever holds low
  logic irqOut_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irqOut_q <= 1'b0;
    end else begin
      irqOut_q <= 1'b0;
    end
  end
  assign irqOut = irqOut_q;
  assign irqOeN = irqOeN_q;
  assign dataOut = dataOut_q;
  assign dataOeN = dataOeN_q;
  assign toneP = toneP_q;
  assign toneN = toneN_q;
  assign cfg = cfg_q;
  assign wdtFlag = wdtFlag_q;

  // checks
  AST_CS_RESET: assert property (@(posedge sys_clk) disable iff (rst)
    csHigh |=> state_q == lcs_pkg::ST_MODE && bitCnt_q == 4'h0) else $error("serial not reset");
  AST_CS_NO_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
    csHigh |-> !ramWe && !clrWdt && !clrTmr) else $error("transfer while deselected");
  AST_OE_READ: assert property (@(posedge sys_clk) disable iff (rst)
    !dataOeN_q |-> $past(state_d) == lcs_pkg::ST_RDATA && !$past(csHigh)) else $error("data driven outside read");
  AST_RD_LAUNCH: assert property (@(posedge sys_clk) disable iff (rst)
    rdFall && !csHigh && state_q == lcs_pkg::ST_RDATA |=> dataOut_q == $past(ramQ[bitCnt_q[1:0]]))
    else $error("read bit not launched");
  AST_WR_SAMPLE: assert property (@(posedge sys_clk) disable iff (rst)
    wrRise && !csHigh && state_q == lcs_pkg::ST_WDATA |=> shift_q[3] == $past(din)) else $error("write bit lost");
  AST_ADDR_INC: assert property (@(posedge sys_clk) disable iff (rst)
    ramWe |=> addr_q == $past(addr_q) + 5'h01) else $error("address did not advance");
  AST_IRQ_OD: assert property (@(posedge sys_clk) disable iff (rst)
    !irqOut_q) else $error("irq driven high");
  AST_TONE_OFF: assert property (@(posedge sys_clk) disable iff (rst)
    !(cfg_q.sysEn && cfg_q.toneOn) |=> !toneP_q && !toneN_q) else $error("tone not low");
  AST_TONE_DIFF: assert property (@(posedge sys_clk) disable iff (rst)
    toneEn ##1 toneEn |=> toneP_q != toneN_q) else $error("tone pair not differential");
  AST_WDT_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
    wdtFlag_q && cfg_q.irqEn && cfg_q.wdtMode |=> !irqOeN_q) else $error("irq released early");
  COV_WRITE: cover property (@(posedge sys_clk) disable iff (rst) ramWe);
  COV_READ: cover property (@(posedge sys_clk) disable iff (rst) rdFall && state_q == lcs_pkg::ST_RDATA);
  COV_WDT: cover property (@(posedge sys_clk) disable iff (rst) !irqOeN_q && wdtFlag_q);
  COV_TONE: cover property (@(posedge sys_clk) disable iff (rst) toneP_q && cfg_q.tone4k);
endmodule

// ===== verification/lcd_controller_host_serial_port_bench.sv
// self-checking bench of the lcd serial port, host model on the pins
// assumes short time base and tone divisors set below
module lcd_controller_host_serial_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TB_DIV_T = 4; // short time base tick
  localparam int TONE_HALF_T = 4; // short tone half period
  localparam int LIMIT = 40000; // hang ceiling in cycles
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic csN, wrN, rdN, dataPin, dataOut, dataOeN, irqOut, irqOeN, toneP, toneN, wdtFlag;
  lcs_pkg::lcs_cfg_s cfg;
  int miscompares = 0;
  int totalChecks = 0;
  int cycles = 0;
  logic [7:0] rd; // read back pair of nibbles
  int n; // tone toggle count
  logic [7:0] srcCmd [3] = '{lcs_pkg::CMD_SRC_XTAL, lcs_pkg::CMD_SRC_EXT, lcs_pkg::CMD_SRC_RC};
  logic [1:0] srcVal [3] = '{lcs_pkg::SRC_XTAL, lcs_pkg::SRC_EXT, lcs_pkg::SRC_RC};
  // device under test
  lcs_serial_port #(.TB_DIV(TB_DIV_T), .TONE_HALF(TONE_HALF_T)) lcs_serial_port_inst (
    .sys_clk(sys_clk), .rst(rst), .csN(csN), .wrN(wrN), .rdN(rdN), .dataIn(dataPin),
    .dataOut(dataOut), .dataOeN(dataOeN), .irqOut(irqOut), .irqOeN(irqOeN),
    .toneP(toneP), .toneN(toneN), .cfg(cfg), .wdtFlag(wdtFlag));
  // host on the far side
  lcs_host_model lcs_host_model_inst (
    .sys_clk(sys_clk), .csN(csN), .wrN(wrN), .rdN(rdN), .dataPin(dataPin),
    .dataOut(dataOut), .dataOeN(dataOeN));
  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;
  // verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    totalChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // count tone edges over 80 cycles, pair opposite at the end
  task automatic countTone(output int cnt);
    logic prev;
    cnt = 0;
    prev = toneP;
    repeat (80) begin
      @(posedge sys_clk);
      #1.2;
      if (toneP !== prev) cnt++;
      prev = toneP;
    end
    chk(toneN, !toneP);
  endtask
  // hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      summarize();
    end
  end
  // main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    #1.2;
    rst = 1'b0;
    repeat (4) @(posedge sys_clk);
    chk(cfg, lcs_pkg::CFG_RESET);
    chk({dataOeN, irqOeN, irqOut, toneP, toneN}, 16'h18);
    // last address then wrap to zero
    lcs_host_model_inst.writeFrame(5'h1f, 8'ha5, 1'b1, 8);
    lcs_host_model_inst.readFrame(5'h1f, rd);
    chk(rd, 8'ha5);
    chk(dataOeN, 1'b1);
    // deselected frame leaves the ram alone
    lcs_host_model_inst.writeFrame(5'h1f, 8'h3c, 1'b0, 8);
    lcs_host_model_inst.readFrame(5'h1f, rd);
    chk(rd, 8'ha5);
    // partial second nibble dropped at deselect
    lcs_host_model_inst.writeFrame(5'h1f, 8'h0f, 1'b1, 6);
    lcs_host_model_inst.readFrame(5'h1f, rd);
    chk(rd, 8'haf);
    // duty, time base and clock source settings
    for (int x = 0; x < 3; x++) begin
      lcs_host_model_inst.cmdFrame(8'h20 | 8'(x));
      chk(cfg.comSel, 16'(x));
    end
    for (int x = 7; x >= 0; x--) begin
      lcs_host_model_inst.cmdFrame(8'ha0 | 8'(x));
      chk(cfg.tbSel, 16'(x));
    end
    for (int x = 0; x < 3; x++) begin
      lcs_host_model_inst.cmdFrame(srcCmd[x]);
      chk(cfg.clkSrc, srcVal[x]);
    end
    // tone at both rates, then off and system off
    lcs_host_model_inst.cmdFrame(lcs_pkg::CMD_SYS_EN);
    lcs_host_model_inst.cmdFrame(lcs_pkg::CMD_TONE4K);
    lcs_host_model_inst.cmdFrame(lcs_pkg::CMD_TONE_ON);
    countTone(n);
    chk(n >= 19 && n <= 21, 1'b1);
    lcs_host_model_inst.cmdFrame(lcs_pkg::CMD_TONE2K);
    countTone(n);
    chk(n >= 9 && n <= 11, 1'b1);
    lcs_host_model_inst.cmdFrame(lcs_pkg::CMD_TONE_OFF);
    chk({toneP, toneN}, 2'b00);
    lcs_host_model_inst.cmdFrame(lcs_pkg::CMD_TONE_ON);
    lcs_host_model_inst.cmdFrame(lcs_pkg::CMD_SYS_DIS);
    chk({toneP, toneN}, 2'b00);
    // watchdog runs out after four counter wraps
    lcs_host_model_inst.cmdFrame(lcs_pkg::CMD_SYS_EN);
    lcs_host_model_inst.cmdFrame(lcs_pkg::CMD_CLR_WDT);
    lcs_host_model_inst.cmdFrame(lcs_pkg::CMD_WDT_EN);
    lcs_host_model_inst.cmdFrame(lcs_pkg::CMD_IRQ_EN);
    repeat (3500) @(posedge sys_clk);
    chk(irqOeN, 1'b1);
    repeat (1200) @(posedge sys_clk);
    chk({irqOeN, irqOut, wdtFlag}, 3'b001);
    repeat (300) @(posedge sys_clk);
    chk(irqOeN, 1'b0);
    lcs_host_model_inst.cmdFrame(lcs_pkg::CMD_CLR_WDT);
    chk({irqOeN, wdtFlag}, 2'b10);
    summarize();
  end
endmodule

// ===== verification/lcs_host_model.sv
// host side of the serial port: chip select, strobes and the data pin
// assumes the bench resolves nothing else on the data pin; pull-up wins when idle
module lcs_host_model (
  // clock for aligning frame starts
  input wire logic sys_clk,
  // strobes toward the device
  output logic csN,
  output logic wrN,
  output logic rdN,
  // resolved data pin level
  output wire logic dataPin,
  // device side of the data pin
  input wire logic dataOut,
  input wire logic dataOeN
);
  timeunit 1ns;
  timeprecision 100ps;
  logic hostOe; // host drives the data pin
  logic hostDat; // level the host drives
  // pin level: contention shows as unknown, released pin pulled high
  assign dataPin = (!dataOeN && hostOe) ? 1'bx : (!dataOeN ? dataOut : (hostOe ? hostDat : 1'b1));
  // strobes idle high outside frames
  initial begin
    csN = 1'b1;
    wrN = 1'b1;
    rdN = 1'b1;
    hostOe = 1'b0;
    hostDat = 1'b1;
  end
  // one write bit: data set while strobe low, taken at its rise
  task automatic wrBit(input logic b);
    hostOe = 1'b1;
    hostDat = b;
    wrN = 1'b0;
    #24;
    wrN = 1'b1;
    #12;
    // hold past the rise, then let go before a read can answer
    hostOe = 1'b0;
    #12;
  endtask
  // one read bit: latched just as the strobe rises
  task automatic rdBit(output logic b);
    hostOe = 1'b0;
    rdN = 1'b0;
    #24;
    b = dataPin;
    rdN = 1'b1;
    #24;
  endtask
  // start a frame; sel low keeps the device deselected
  task automatic openFrame(input logic sel);
    @(posedge sys_clk);
    #1.2;
    csN = !sel;
    #24;
  endtask
  // end a frame and give the sync chain time to see it
  task automatic closeFrame();
    hostOe = 1'b0;
    #24;
    csN = 1'b1;
    #48;
  endtask
  // write frame: mode, address msb first, data lsb first
  task automatic writeFrame(input logic [4:0] addr, input logic [7:0] data, input logic sel, input int dataBits);
    openFrame(sel);
    wrBit(1'b1);
    wrBit(1'b0);
    wrBit(1'b1);
    for (int i = 4; i >= 0; i--) wrBit(addr[i]);
    for (int i = 0; i < dataBits; i++) wrBit(data[i]);
    closeFrame();
  endtask
  // read frame: two nibbles back, lsb first
  task automatic readFrame(input logic [4:0] addr, output logic [7:0] data);
    openFrame(1'b1);
    wrBit(1'b1);
    wrBit(1'b1);
    wrBit(1'b0);
    for (int i = 4; i >= 0; i--) wrBit(addr[i]);
    hostOe = 1'b0;
    #48;
    for (int i = 0; i < 8; i++) rdBit(data[i]);
    closeFrame();
  endtask
  // command frame: code msb first, then the spare bit
  task automatic cmdFrame(input logic [7:0] code);
    openFrame(1'b1);
    wrBit(1'b1);
    wrBit(1'b0);
    wrBit(1'b0);
    for (int i = 7; i >= 0; i--) wrBit(code[i]);
    wrBit(1'b0);
    closeFrame();
  endtask
endmodule
